// ==== core/lowlat_defines.svh ====
// Functional notes
// - Address and control are captured on the rising edge of the input clock.
// - Commands are taken only while chip select is low; work in flight continues.
// - Write and refresh strobes, with chip select, choose the command.
// - Read and write take the location from the address sampled that cycle.
// - Mode register set loads settings from the address sampled that cycle.
// - Expansion-only address bits never change behaviour.
// - Read valid flag is high exactly while read data on the bus is valid.
// - Each command goes to the bank selected by the bank inputs that cycle. Here the bank only sets last_bank; the storage index ignores it.
// - Masked write data leaves the memory contents unchanged.
`ifndef LOWLAT_DEFINES_SVH
`define LOWLAT_DEFINES_SVH
`define LL_ADDR_W        22
`define LL_BANK_W        3
`define LL_DATA_W        36
`define LL_CFG_W         18
`define LL_CFG_RESET     18'h00000
`define LL_READ_LAT      3
`define LL_WORD_LIMIT_36 20
`define LL_WORD_LIMIT_18 21
`endif

// ==== core/lowlat_dram_cmd_addr_input.sv ====
`timescale 1ns/10ps
`include "lowlat_defines.svh"
// Command, address and bank capture; command side on the input clock,
// read-valid side on the output data clock.
module lowlat_dram_cmd_addr_input #(
  parameter lowlat_pkg::org_t ORG     = lowlat_pkg::ORG_X36,
  parameter int               INDEX_W = 6,
  parameter int               READ_LAT = `LL_READ_LAT
) (
  // Input clock domain
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  cs_n,
  input  wire logic                  we_n,
  input  wire logic                  ref_n,
  input  wire logic [`LL_ADDR_W-1:0] location_inputs,
  input  wire logic [`LL_BANK_W-1:0] bank_select_inputs,
  input  wire logic [`LL_DATA_W-1:0] write_data,
  input  wire logic                  write_mask,
  // Output data clock domain
  input  wire logic                  output_data_clock,
  input  wire logic                  out_rst,
  output logic      [`LL_DATA_W-1:0] bidir_data_bus_out,
  output logic                       bidir_data_bus_oe,
  output logic                       read_valid_flag,
  // Status
  output logic      [`LL_CFG_W-1:0]  mode_config,
  output logic      [`LL_BANK_W-1:0] last_bank,
  output logic                       refresh_pulse
);
  localparam int LIMIT = (ORG == lowlat_pkg::ORG_X36) ? `LL_WORD_LIMIT_36 :
                         (ORG == lowlat_pkg::ORG_X18) ? `LL_WORD_LIMIT_18 : `LL_ADDR_W;

  // Decoded command of the current edge
  lowlat_pkg::cmd_t cmd;
  logic [`LL_ADDR_W-1:0] loc_used;

  // Strobes plus chip select pick the command; high select ignores it
  always_comb begin
    cmd = lowlat_pkg::CMD_NOP;
    if (!cs_n) begin
      case ({we_n, ref_n})
        2'b11:   cmd = lowlat_pkg::CMD_READ;
        2'b01:   cmd = lowlat_pkg::CMD_WRITE;
        2'b10:   cmd = lowlat_pkg::CMD_REFRESH;
        2'b00:   cmd = lowlat_pkg::CMD_MRS;
        default: cmd = lowlat_pkg::CMD_NOP;
      endcase
    end
  end

  // Expansion bits are dropped so they cannot steer anything
  always_comb begin
    loc_used = location_inputs;
    for (int i = 0; i < `LL_ADDR_W; i++) begin
      if (i >= LIMIT) loc_used[i] = 1'b0;
    end
  end

  // Command-side state
  logic [`LL_CFG_W-1:0]  next_mode_config;
  logic [`LL_BANK_W-1:0] next_last_bank;
  logic                  next_refresh_pulse;
  logic [READ_LAT-1:0]   rd_pipe;
  logic [READ_LAT-1:0]   next_rd_pipe;
  logic                  rd_toggle;
  logic                  next_rd_toggle;

  always_comb begin
    next_mode_config   = mode_config;
    next_last_bank     = last_bank;
    next_refresh_pulse = 1'b0;
    next_rd_pipe       = {rd_pipe[READ_LAT-2:0], 1'b0};
    next_rd_toggle     = rd_toggle;
    if (cmd != lowlat_pkg::CMD_NOP) begin
      next_last_bank = bank_select_inputs;
    end
    case (cmd)
      lowlat_pkg::CMD_MRS:     next_mode_config = location_inputs[`LL_CFG_W-1:0];
      lowlat_pkg::CMD_REFRESH: next_refresh_pulse = 1'b1;
      lowlat_pkg::CMD_READ:    next_rd_pipe[0] = 1'b1;
      default:                 next_refresh_pulse = 1'b0;
    endcase
    // Toggle carries the read event to the output clock domain
    if (rd_pipe[READ_LAT-1]) next_rd_toggle = ~rd_toggle;
  end

  // Captured on the rising edge of the input clock
  always_ff @(posedge clk) begin
    if (rst) begin
      mode_config   <= `LL_CFG_RESET;
      last_bank     <= '0;
      refresh_pulse <= 1'b0;
      rd_pipe       <= '0;
      rd_toggle     <= 1'b0;
    end else begin
      mode_config   <= next_mode_config;
      last_bank     <= next_last_bank;
      refresh_pulse <= next_refresh_pulse;
      rd_pipe       <= next_rd_pipe;
      rd_toggle     <= next_rd_toggle;
    end
  end

  // Storage: the low INDEX_W location bits form the index, bank bits fall outside it; mask keeps old data
  logic [INDEX_W-1:0]    index;
  logic [`LL_DATA_W-1:0] rd_word;
  logic [`LL_DATA_W-1:0] rd_hold;
  logic                  wr_en;
  assign index = INDEX_W'({bank_select_inputs, loc_used});
  assign wr_en = (cmd == lowlat_pkg::CMD_WRITE);

  lowlat_store #(
    .DATA_W  (`LL_DATA_W),
    .INDEX_W (INDEX_W)
  ) u_store (
    .clk      (clk),
    .wr_en    (wr_en),
    .wr_index (index),
    .wr_data  (write_data),
    .wr_keep  ({`LL_DATA_W{write_mask}}),
    .rd_index (index),
    .rd_data  (rd_word)
  );

  // Hold read word stable while it crosses; latched on the first pipe stage
  always_ff @(posedge clk) begin
    if (rst) begin
      rd_hold <= '0;
    end else if (rd_pipe[0]) begin
      rd_hold <= rd_word;
    end
  end

  // Output domain: toggle synchroniser, the word is stable by then
  logic                  tgl_s1;
  logic                  tgl_s2;
  logic                  tgl_s3;
  logic                  next_valid;
  logic [`LL_DATA_W-1:0] next_dq;

  always_comb begin
    next_valid = tgl_s2 ^ tgl_s3;
    next_dq    = next_valid ? rd_hold : bidir_data_bus_out;
  end

  // Valid flag and data change on the same output clock edge
  always_ff @(posedge output_data_clock) begin
    if (out_rst) begin
      tgl_s1             <= 1'b0;
      tgl_s2             <= 1'b0;
      tgl_s3             <= 1'b0;
      read_valid_flag    <= 1'b0;
      bidir_data_bus_oe  <= 1'b0;
      bidir_data_bus_out <= '0;
    end else begin
      tgl_s1             <= rd_toggle;
      tgl_s2             <= tgl_s1;
      tgl_s3             <= tgl_s2;
      read_valid_flag    <= next_valid;
      bidir_data_bus_oe  <= next_valid;
      bidir_data_bus_out <= next_dq;
    end
  end
endmodule // lowlat_dram_cmd_addr_input

// ==== core/lowlat_pkg.sv ====
package lowlat_pkg;
  typedef enum logic [4:0] {
    CMD_NOP     = 5'h01,
    CMD_READ    = 5'h02,
    CMD_WRITE   = 5'h04,
    CMD_REFRESH = 5'h08,
    CMD_MRS     = 5'h10
  } cmd_t;
  typedef enum logic [1:0] {
    ORG_X9  = 2'h0,
    ORG_X18 = 2'h1,
    ORG_X36 = 2'h2
  } org_t;
endpackage

// ==== core/lowlat_store.sv ====
`timescale 1ns/10ps
// Small array standing in for the core; read data come from a register
module lowlat_store #(
  parameter int DATA_W  = 36,
  parameter int INDEX_W = 6
) (
  // Clock
  input  wire logic               clk,
  // Write port, per-bit keep mask
  input  wire logic               wr_en,
  input  wire logic [INDEX_W-1:0] wr_index,
  input  wire logic [DATA_W-1:0]  wr_data,
  input  wire logic [DATA_W-1:0]  wr_keep,
  // Read port
  input  wire logic [INDEX_W-1:0] rd_index,
  output logic      [DATA_W-1:0]  rd_data
);
  logic [DATA_W-1:0] mem [0:(1<<INDEX_W)-1];

  // Kept bits are written back unchanged, masked lanes never disturbed
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_index] <= (mem[wr_index] & wr_keep) | (wr_data & ~wr_keep);
    end
    rd_data <= mem[rd_index];
  end
endmodule // lowlat_store

// ==== sim/lowlat_cmd_checker.sv ====
`timescale 1ns/10ps
`include "lowlat_defines.svh"
// Watches command capture and the read-valid beat at the top ports
module lowlat_cmd_checker (
  // Input clock domain
  input wire logic                  clk,
  input wire logic                  rst,
  input wire logic                  cs_n,
  input wire logic                  we_n,
  input wire logic                  ref_n,
  input wire logic [`LL_ADDR_W-1:0] location_inputs,
  input wire logic [`LL_BANK_W-1:0] bank_select_inputs,
  // Output data clock domain
  input wire logic                  output_data_clock,
  input wire logic                  out_rst,
  input wire logic                  bidir_data_bus_oe,
  input wire logic                  read_valid_flag,
  // Status
  input wire logic [`LL_CFG_W-1:0]  mode_config,
  input wire logic [`LL_BANK_W-1:0] last_bank,
  input wire logic                  refresh_pulse
);
  // Commands as decoded at the rising edge
  wire logic cfg_cmd = !cs_n && !we_n && !ref_n;
  wire logic rfr_cmd = !cs_n && we_n && !ref_n;
  wire logic rd_cmd  = !cs_n && we_n && ref_n;

  a_cfg_load: assert property (@(posedge clk) disable iff (rst)
    cfg_cmd |=> mode_config == $past(location_inputs[17:0])) else $error("config not loaded");
  a_cfg_hold: assert property (@(posedge clk) disable iff (rst)
    !cfg_cmd |=> $stable(mode_config)) else $error("config changed");
  a_bank_take: assert property (@(posedge clk) disable iff (rst)
    !cs_n |=> last_bank == $past(bank_select_inputs)) else $error("bank not taken");
  a_bank_hold: assert property (@(posedge clk) disable iff (rst)
    cs_n |=> $stable(last_bank)) else $error("bank changed while deselected");
  a_ref_pulse: assert property (@(posedge clk) disable iff (rst)
    rfr_cmd |=> refresh_pulse) else $error("refresh missing");
  a_ref_only: assert property (@(posedge clk) disable iff (rst)
    !rfr_cmd |=> !refresh_pulse) else $error("spurious refresh");
  // A 12 ns beat always spans one 8 ns edge, so the input clock sees it
  a_read_answer: assert property (@(posedge clk) disable iff (rst)
    rd_cmd |-> ##[4:24] read_valid_flag) else $error("read never valid");
  a_valid_single: assert property (@(posedge output_data_clock) disable iff (out_rst)
    read_valid_flag |=> !read_valid_flag) else $error("valid beat too long");
  a_valid_drive: assert property (@(posedge output_data_clock) disable iff (out_rst)
    read_valid_flag == bidir_data_bus_oe) else $error("valid and enable differ");
endmodule // lowlat_cmd_checker

bind lowlat_dram_cmd_addr_input lowlat_cmd_checker i_chk (.clk, .rst, .cs_n, .we_n, .ref_n, .location_inputs,
  .bank_select_inputs, .output_data_clock, .out_rst, .bidir_data_bus_oe, .read_valid_flag, .mode_config,
  .last_bank, .refresh_pulse);

// ==== sim/lowlat_ctrl_model.sv ====
`timescale 1ns/10ps
// Controller end of the read path: takes one word per valid beat
module lowlat_ctrl_model (
  // Output data clock side
  input  wire logic        output_data_clock,
  input  wire logic        read_valid_flag,
  input  wire logic [35:0] bidir_data_bus_out,
  // Captured read data
  output logic      [35:0] got_word,
  output int               got_count
);
  // Bus content is ignored unless the flag marks it valid
  initial got_count = 0;
  always @(posedge output_data_clock)
    if (read_valid_flag === 1'b1) begin
      got_word  <= bidir_data_bus_out;
      got_count <= got_count + 1;
    end
endmodule // lowlat_ctrl_model

// ==== sim/tb_top.sv ====
`timescale 1ns/10ps
module tb_top;
  logic        clk, rst, cs_n, we_n, ref_n, oclk, out_rst, mask, oe, vld, rpls;
  logic [21:0] addr;
  logic [2:0]  bank, lbank, ebank = 3'h0;
  logic [35:0] wdata, q, got, mem [64];
  logic [17:0] cfg, ecfg = 18'h00000;
  int          fails, samples_checked, cnt, n, r;

  lowlat_dram_cmd_addr_input i_dut (.clk(clk), .rst(rst), .cs_n(cs_n), .we_n(we_n), .ref_n(ref_n),
    .location_inputs(addr), .bank_select_inputs(bank), .write_data(wdata), .write_mask(mask),
    .output_data_clock(oclk), .out_rst(out_rst), .bidir_data_bus_out(q), .bidir_data_bus_oe(oe),
    .read_valid_flag(vld), .mode_config(cfg), .last_bank(lbank), .refresh_pulse(rpls));
  lowlat_ctrl_model i_ctrl (.output_data_clock(oclk), .read_valid_flag(vld), .bidir_data_bus_out(q),
    .got_word(got), .got_count(cnt));

  // Two unrelated clocks
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    oclk = 1'b0;
    #3;
    forever #6 oclk = ~oclk;
  end

  // Expansion bits are dropped before the word index is formed
  function automatic logic [5:0] idx(input logic [21:0] a, input logic [2:0] b);
    return 6'({b, a[19:0]});
  endfunction

  task automatic chk(input string what, input logic [35:0] exp, input logic [35:0] seen);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s exp %h seen %h", what, exp, seen);
    end
  endtask

  // One command cycle, then deselect with scrambled strobes
  task automatic issue(input logic c, w, f, input logic [21:0] a, input logic [2:0] b, input logic [35:0] d,
                       input logic m);
    @(negedge clk);
    {cs_n, we_n, ref_n, addr, bank, wdata, mask} = {c, w, f, a, b, d, m};
    @(negedge clk);
    {cs_n, we_n, ref_n, addr, bank} = {1'b1, ~w, ~f, ~a, ~b};
    if (!c) ebank = b;
    if (!c && !w && !f) ecfg = a[17:0];
    if (!c && !w && f && !m) mem[idx(a, b)] = d;
    chk("refresh_pulse", 36'(!c && w && !f), 36'(rpls));
    chk("last_bank", 36'(ebank), 36'(lbank));
    chk("mode_config", 36'(ecfg), 36'(cfg));
  endtask

  task automatic read_back(input logic [21:0] a, input logic [2:0] b);
    n = cnt;
    issue(1'b0, 1'b1, 1'b1, a, b, 36'h0, 1'b0);
    for (int i = 0; i < 30 && cnt == n; i++) @(negedge clk);
    chk("read_data", mem[idx(a, b)], got);
    chk("read_count", 36'(n + 1), 36'(cnt));
    repeat (4) @(negedge clk);
  endtask

  task automatic report_and_stop;
    $display("checked %0d fails %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Main sequence: fill, corner cases, random traffic
  initial begin
    void'($urandom(32'h424acddd));
    {rst, out_rst, cs_n, we_n, ref_n, mask, addr, bank, wdata} = {6'h3f, 61'h0};
    repeat (8) @(negedge clk);
    {rst, out_rst} = 2'h0;
    for (int i = 0; i < 64; i++) issue(1'b0, 1'b0, 1'b1, {16'($urandom), 6'(i)}, 3'($urandom),
                                       {$urandom, 4'($urandom)}, 1'b0);
    issue(1'b0, 1'b0, 1'b0, 22'h3fffff, 3'h7, 36'h0, 1'b0);
    issue(1'b0, 1'b0, 1'b1, 22'h000005, 3'h2, 36'hfffffffff, 1'b1);
    read_back(22'h300005, 3'h5);
    repeat (60) begin
      r = $urandom;
      if (r[1:0] == 2'h3) read_back(22'($urandom), 3'($urandom));
      else issue(r[2] & r[3], r[4], r[5] & !r[4], 22'($urandom), 3'($urandom), {$urandom, 4'($urandom)},
                 r[6]);
    end
    report_and_stop;
  end

  // Hang guard, far beyond the expected few hundred cycles
  initial begin
    #100000;
    fails++;
    report_and_stop;
  end
endmodule // tb_top
